// *** pkg/watchdog_pkg.sv ***
package watchdog_pkg;

  // device operating modes, driven by the surrounding mode controller
  typedef enum logic [2:0] {
    MODE_INIT      = 3'h0,
    MODE_NORMAL    = 3'h1,
    MODE_STOP      = 3'h2,
    MODE_SLEEP     = 3'h3,
    MODE_RESTART   = 3'h4,
    MODE_FAIL_SAFE = 3'h5
  } device_mode_t;

  // watchdog timer states, gray along off -> long -> closed -> open
  typedef enum logic [1:0] {
    WD_OFF    = 2'h0,
    WD_LONG   = 2'h1,
    WD_CLOSED = 2'h3,
    WD_OPEN   = 2'h2
  } wd_state_t;

  // data byte of the watchdog control register, bit 7 is the check bit
  typedef struct packed {
    logic       checksum;
    logic       stop_disable_step_b;
    logic       window_type_select;
    logic       reserved_4;
    logic       reserved_3;
    logic [2:0] period_select;
  } wd_control_t;

  // one 16-bit frame, shifted in lsb first: address, write flag, data
  typedef struct packed {
    logic [7:0] data;
    logic       write;
    logic [6:0] address;
  } spi_frame_t;

  localparam int          FRAME_BITS        = 16;
  localparam logic [4:0]  FRAME_BITS_5      = 5'h10;
  localparam logic [4:0]  FRAME_COUNT_MAX   = 5'h11;
  localparam logic [6:0]  ADDR_WD_CONTROL   = 7'h03;
  localparam logic [6:0]  ADDR_WAKE_CONTROL = 7'h04;
  localparam int          WAKE_STEP_A_BIT   = 2;

  localparam logic [2:0]  RESET_PERIOD      = 3'h0;
  localparam logic        RESET_WINDOW_TYPE = 1'b0;

  localparam int          CLOCK_HZ          = 40_000_000;
  localparam int          TICK_TIME_US      = 1000;
  localparam int          TICK_CYCLES       =
    CLOCK_HZ / 1_000_000 * TICK_TIME_US;
  localparam int          TRIGGER_DELAY_CYC = 3;
  localparam logic [1:0]  TRIGGER_DELAY_2   = 2'h3;

  localparam logic [14:0] LONG_WINDOW_MS    = 15'h00c8;
  localparam int          CLOSED_PERCENT    = 60;
  localparam int          OPEN_END_PERCENT  = 140;

  localparam logic [1:0]  FAIL_SAT_CONFIG2  = 2'h1;
  localparam logic [1:0]  FAIL_SAT_OTHER    = 2'h2;
  localparam logic [1:0]  FAIL_CONFIG2      = 2'h1;

endpackage : watchdog_pkg

// *** rtl/window_timeout_watchdog.sv ***
// What this block does
// - time-out or window watchdog chosen by a control bit; time-out after reset
// - type and timing change only in normal mode; stop mode keeps them
// - init mode starts a long open window once reset output is released
// - off in sleep and restart; long open window on entering normal mode
// - new timing written restarts the timer at once with that setting
// - a valid control write in normal or enabled stop mode is a trigger, acted on 3 cycles after select rises
// - long open window of 200 ms accepts any valid trigger
// - period select gives 10,20,50,100,200,500,1000,10000 ms
// - failure asserts reset, enters restart or fail-safe, counts; then normal
// - development mode disables the watchdog entirely
// - closed-window trigger or expiry increments the failure counter
// - failure counter saturates at 01 for config 2, at 10 otherwise
// - failure counter clears on good trigger, in sleep, in disabled stop and in fail-safe not entered by a watchdog failure
// - time-out: trigger anywhere in the period restarts a full period
// - time-out: expiry asserts reset and leaves for restart or fail-safe
// - window: closed window of 60 percent then an open window
// - window: trigger in open window starts a new closed window
// - window: closed-window trigger or expiry asserts reset and leaves
// - even parity over the data byte; bad parity ignored, error flag set
// - parity includes the written reserved bit 3, which reads as zero
// - a sequence violation clears the first stop-disable step
// - stop trigger or return to normal clears steps; a disabled-stop trigger or return to normal restarts long window
module window_timeout_watchdog #(
  parameter int TICK_CYCLES = watchdog_pkg::TICK_CYCLES
) (
  input  wire logic                       i_clock,
  input  wire logic                       i_reset,
  input  wire logic                       i_enable,
  input  wire logic                       i_spi_clock,
  input  wire logic                       i_chip_select_low,
  input  wire logic                       i_spi_data_in,
  input  wire watchdog_pkg::device_mode_t i_device_mode,
  input  wire logic                       i_development_mode,
  input  wire logic [1:0]                 i_failure_config,
  input  wire logic                       i_fail_safe_on_failure,
  input  wire logic                       i_reset_released,
  input  wire logic                       i_spi_error_clear,
  output logic                            o_reset_output_low,
  output logic                            o_enter_restart,
  output logic                            o_enter_fail_safe,
  output logic                            o_enter_normal,
  output logic                            o_spi_error,
  output logic                            o_window_type_select,
  output logic [2:0]                      o_period_select,
  output logic [1:0]                      o_failure_counter,
  output logic                            o_stop_disable_step_a,
  output logic                            o_stop_disable_step_b,
  output logic [7:0]                      o_control_readback,
  output watchdog_pkg::wd_state_t         o_watchdog_state
);

  // period table in milliseconds
  function automatic logic [14:0] period_ms(input logic [2:0] sel);
    case (sel)
      3'h0:    period_ms = 15'h000a;
      3'h1:    period_ms = 15'h0014;
      3'h2:    period_ms = 15'h0032;
      3'h3:    period_ms = 15'h0064;
      3'h4:    period_ms = 15'h00c8;
      3'h5:    period_ms = 15'h01f4;
      3'h6:    period_ms = 15'h03e8;
      default: period_ms = 15'h2710;
    endcase
  endfunction : period_ms

  function automatic logic [14:0] percent_of(input logic [14:0] ms,
                                             input int          pct);
    int prod;
    prod = int'(ms) * pct / 100;
    percent_of = prod[14:0];
  endfunction : percent_of

  // link side, runs on the spi clock only while a frame is in progress
  logic [15:0] shift_q;
  logic [4:0]  bit_count_q;
  logic        first_edge_q;

  // set while deselected so the next frame restarts its count; the count
  // itself stays put after the frame so the core can judge its length
  always_ff @(posedge i_spi_clock or posedge i_chip_select_low) begin
    if (i_chip_select_low) begin
      first_edge_q <= 1'b1;
    end else begin
      first_edge_q <= 1'b0;
    end
  end

  always_ff @(posedge i_spi_clock) begin
    shift_q <= {i_spi_data_in, shift_q[15:1]};
  end

  always_ff @(posedge i_spi_clock) begin
    if (first_edge_q) begin
      bit_count_q <= 5'h01;
    end else if (bit_count_q != watchdog_pkg::FRAME_COUNT_MAX) begin
      bit_count_q <= bit_count_q + 5'h01;
    end
  end

  // core side: chip select passes two flops; frame words are read only
  // after the synchronised rise, when the spi clock is idle
  logic                    cs_meta_q;
  logic                    cs_sync_q;
  logic                    cs_prev_q;
  logic                    cs_rise;
  logic [1:0]              delay_q;
  logic                    pending_q;
  logic                    execute;
  watchdog_pkg::spi_frame_t frame_q;
  logic                    frame_len_ok_q;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      cs_meta_q <= 1'b1;
      cs_sync_q <= 1'b1;
      cs_prev_q <= 1'b1;
    end else if (i_enable) begin
      cs_meta_q <= i_chip_select_low;
      cs_sync_q <= cs_meta_q;
      cs_prev_q <= cs_sync_q;
    end
  end

  assign cs_rise = cs_sync_q & ~cs_prev_q;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      frame_q        <= '0;
      frame_len_ok_q <= 1'b0;
    end else if (i_enable && cs_rise) begin
      frame_q        <= shift_q;
      frame_len_ok_q <= (bit_count_q == watchdog_pkg::FRAME_BITS_5);
    end
  end

  // the command is interpreted a fixed number of cycles after select rises
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      pending_q <= 1'b0;
      delay_q   <= 2'h0;
    end else if (i_enable) begin
      if (cs_rise) begin
        pending_q <= 1'b1;
        delay_q   <= 2'h1;
      end else if (pending_q) begin
        delay_q <= delay_q + 2'h1;
        if (delay_q == watchdog_pkg::TRIGGER_DELAY_2) begin
          pending_q <= 1'b0;
        end
      end
    end
  end

  assign execute = i_enable && pending_q &&
                   delay_q == watchdog_pkg::TRIGGER_DELAY_2 &&
                   frame_len_ok_q && frame_q.write;

  watchdog_pkg::wd_control_t ctrl_in;
  logic                      parity_ok;
  logic                      wd_write;
  logic                      wake_write;
  logic                      is_normal;
  logic                      is_stop;

  assign ctrl_in    = frame_q.data;
  assign parity_ok  = ~^frame_q.data;
  assign wd_write   = execute &&
                      frame_q.address == watchdog_pkg::ADDR_WD_CONTROL;
  assign wake_write = execute &&
                      frame_q.address == watchdog_pkg::ADDR_WAKE_CONTROL;
  assign is_normal  = i_device_mode == watchdog_pkg::MODE_NORMAL;
  assign is_stop    = i_device_mode == watchdog_pkg::MODE_STOP;

  logic good_write;
  assign good_write = wd_write & parity_ok;

  // sticky error flag; a new error wins over a clear in the same cycle
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_spi_error <= 1'b0;
    end else if (i_enable) begin
      if (wd_write && !parity_ok) begin
        o_spi_error <= 1'b1;
      end else if (i_spi_error_clear) begin
        o_spi_error <= 1'b0;
      end
    end
  end

  // mode tracking
  watchdog_pkg::device_mode_t mode_prev_q;
  logic                       released_prev_q;
  logic                       normal_entry;
  logic                       release_rise;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      mode_prev_q     <= watchdog_pkg::MODE_INIT;
      released_prev_q <= 1'b0;
    end else if (i_enable) begin
      mode_prev_q     <= i_device_mode;
      released_prev_q <= i_reset_released;
    end
  end

  assign normal_entry = is_normal &&
                        mode_prev_q != watchdog_pkg::MODE_NORMAL;
  assign release_rise = i_reset_released & ~released_prev_q;

  // configuration, writable only in normal mode
  logic config_write;
  logic config_change;
  assign config_write  = good_write & is_normal;
  assign config_change = config_write &&
                         (ctrl_in.period_select != o_period_select ||
                          ctrl_in.window_type_select != o_window_type_select);

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_window_type_select <= watchdog_pkg::RESET_WINDOW_TYPE;
      o_period_select      <= watchdog_pkg::RESET_PERIOD;
    end else if (i_enable && config_write) begin
      o_window_type_select <= ctrl_in.window_type_select;
      o_period_select      <= ctrl_in.period_select;
    end
  end

  // reserved bits read back as zero regardless of what was written
  always_comb begin
    o_control_readback                     = '0;
    o_control_readback[7]                  = ^{o_stop_disable_step_b,
                                               o_window_type_select,
                                               o_period_select};
    o_control_readback[6]                  = o_stop_disable_step_b;
    o_control_readback[5]                  = o_window_type_select;
    o_control_readback[2:0]                = o_period_select;
  end

  // stop-mode disable sequence: step a in the wake register first,
  // then step b in the watchdog control register
  logic stop_disabled;
  logic stop_trigger;
  assign stop_disabled = o_stop_disable_step_a & o_stop_disable_step_b;
  assign stop_trigger  = good_write & is_stop;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_stop_disable_step_a <= 1'b0;
      o_stop_disable_step_b <= 1'b0;
    end else if (i_enable) begin
      if (stop_trigger || normal_entry) begin
        o_stop_disable_step_a <= 1'b0;
        o_stop_disable_step_b <= 1'b0;
      end else if (is_normal && wake_write) begin
        o_stop_disable_step_a <=
          frame_q.data[watchdog_pkg::WAKE_STEP_A_BIT];
        if (frame_q.data[watchdog_pkg::WAKE_STEP_A_BIT]) begin
          o_stop_disable_step_b <= 1'b0; // restart clears a stale step b
        end
      end else if (config_write) begin
        if (ctrl_in.stop_disable_step_b && o_stop_disable_step_a) begin
          o_stop_disable_step_b <= 1'b1;
        end else if (o_stop_disable_step_a && !o_stop_disable_step_b) begin
          o_stop_disable_step_a <= 1'b0;
        end else if (!ctrl_in.stop_disable_step_b) begin
          o_stop_disable_step_b <= 1'b0;
        end
      end
    end
  end

  // millisecond prescaler
  logic [$clog2(TICK_CYCLES)-1:0] prescale_q;
  logic                           ms_tick;
  assign ms_tick = prescale_q == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1);

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      prescale_q <= '0;
    end else if (i_enable) begin
      prescale_q <= ms_tick ? '0 : prescale_q + 1'b1;
    end
  end

  // watchdog timer
  watchdog_pkg::wd_state_t state_q;
  logic [14:0]             ms_q;
  logic [14:0]             period_now;
  logic [14:0]             closed_end;
  logic [14:0]             open_end;
  logic                    wd_off_cond;
  logic                    start_long;
  logic                    trigger;
  logic                    fail;
  logic                    expired;
  logic                    fail_by_watchdog_q;

  assign period_now = period_ms(o_period_select);
  assign closed_end = percent_of(period_now,
                                 watchdog_pkg::CLOSED_PERCENT);
  assign open_end   = o_window_type_select ?
                      percent_of(period_now, watchdog_pkg::OPEN_END_PERCENT)
                      : period_now;

  assign wd_off_cond = i_development_mode ||
                       i_device_mode == watchdog_pkg::MODE_SLEEP ||
                       i_device_mode == watchdog_pkg::MODE_RESTART ||
                       i_device_mode == watchdog_pkg::MODE_FAIL_SAFE ||
                       (is_stop && stop_disabled && !stop_trigger);

  assign start_long = (release_rise &&
                       i_device_mode == watchdog_pkg::MODE_INIT) ||
                      normal_entry ||
                      (stop_trigger && stop_disabled);

  assign trigger = good_write && (is_normal || (is_stop && !stop_disabled));

  always_comb begin
    expired = 1'b0;
    case (state_q)
      watchdog_pkg::WD_LONG:
        expired = ms_tick && ms_q >= watchdog_pkg::LONG_WINDOW_MS - 15'h1;
      watchdog_pkg::WD_CLOSED,
      watchdog_pkg::WD_OPEN:
        expired = ms_tick && ms_q >= open_end - 15'h1;
      default:
        expired = 1'b0;
    endcase
  end

  // a timing change restarts the period rather than judging the trigger
  assign fail = !wd_off_cond &&
                ((expired && !trigger) ||
                 (trigger && !config_change &&
                  state_q == watchdog_pkg::WD_CLOSED));

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_q <= watchdog_pkg::WD_OFF;
      ms_q    <= '0;
    end else if (i_enable) begin
      if (wd_off_cond || fail) begin
        state_q <= watchdog_pkg::WD_OFF;
        ms_q    <= '0;
      end else if (start_long) begin
        state_q <= watchdog_pkg::WD_LONG;
        ms_q    <= '0;
      end else if (trigger && state_q != watchdog_pkg::WD_OFF) begin
        state_q <= (config_write ? ctrl_in.window_type_select :
                    o_window_type_select) ?
                   watchdog_pkg::WD_CLOSED : watchdog_pkg::WD_OPEN;
        ms_q    <= '0;
      end else if (state_q != watchdog_pkg::WD_OFF && ms_tick) begin
        ms_q <= ms_q + 15'h1;
        if (state_q == watchdog_pkg::WD_CLOSED &&
            ms_q >= closed_end - 15'h1) begin
          state_q <= watchdog_pkg::WD_OPEN;
        end
      end
    end
  end

  assign o_watchdog_state = state_q;

  // failure reaction pulses toward the reset generator and mode control
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_reset_output_low <= 1'b0;
      o_enter_restart    <= 1'b0;
      o_enter_fail_safe  <= 1'b0;
      o_enter_normal     <= 1'b0;
      fail_by_watchdog_q <= 1'b0;
    end else if (i_enable) begin
      o_reset_output_low <= fail;
      o_enter_restart    <= fail && !i_fail_safe_on_failure;
      o_enter_fail_safe  <= fail && i_fail_safe_on_failure;
      o_enter_normal     <= release_rise && fail_by_watchdog_q;
      if (fail) begin
        fail_by_watchdog_q <= 1'b1;
      end else if (normal_entry) begin
        fail_by_watchdog_q <= 1'b0;
      end
    end
  end

  // failure counter
  logic [1:0] fail_limit;
  logic       counter_clear;
  assign fail_limit = i_failure_config == watchdog_pkg::FAIL_CONFIG2 ?
                      watchdog_pkg::FAIL_SAT_CONFIG2 :
                      watchdog_pkg::FAIL_SAT_OTHER;

  assign counter_clear =
    (trigger && !fail) ||
    i_device_mode == watchdog_pkg::MODE_SLEEP ||
    (is_stop && stop_disabled) ||
    (i_device_mode == watchdog_pkg::MODE_FAIL_SAFE && !fail_by_watchdog_q);

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_failure_counter <= 2'h0;
    end else if (i_enable) begin
      if (fail) begin
        if (o_failure_counter < fail_limit) begin
          o_failure_counter <= o_failure_counter + 2'h1;
        end
      end else if (counter_clear) begin
        o_failure_counter <= 2'h0;
      end
    end
  end

endmodule : window_timeout_watchdog

// *** verification/window_timeout_watchdog_props.sv ***
module window_timeout_watchdog_props #(
  parameter int TICK_CYCLES = 40
) (
  input wire logic                       i_clock,
  input wire logic                       i_reset,
  input wire watchdog_pkg::device_mode_t i_device_mode,
  input wire logic                       i_development_mode,
  input wire logic [1:0]                 i_failure_config,
  input wire logic                       i_fail_safe_on_failure,
  input wire logic                       i_spi_error_clear,
  input wire logic                       o_reset_output_low,
  input wire logic                       o_enter_restart,
  input wire logic                       o_enter_fail_safe,
  input wire logic                       o_spi_error,
  input wire logic                       o_window_type_select,
  input wire logic [2:0]                 o_period_select,
  input wire logic [1:0]                 o_failure_counter,
  input wire logic [7:0]                 o_control_readback,
  input wire watchdog_pkg::wd_state_t    o_watchdog_state
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);

  a_reset_one_pulse: assert property (o_reset_output_low |=> !o_reset_output_low)
    else $error("reset request longer than one cycle");
  a_failure_target_mode: assert property (o_reset_output_low |->
    o_enter_fail_safe == i_fail_safe_on_failure &&
    o_enter_restart != i_fail_safe_on_failure)
    else $error("failure entered the wrong mode");
  a_dev_no_reset: assert property (i_development_mode &&
    $past(i_development_mode) && $past(i_development_mode, 2)
    |-> !o_reset_output_low)
    else $error("reset requested in development mode");
  a_count_step_one: assert property (o_failure_counter !=
    $past(o_failure_counter) |-> o_failure_counter == 2'h0 ||
    o_failure_counter == $past(o_failure_counter) + 2'h1)
    else $error("failure counter jumped");
  a_count_sat_limit: assert property (o_failure_counter != 2'h0 &&
    o_failure_counter != $past(o_failure_counter) |->
    o_failure_counter <= (i_failure_config == 2'h1 ? 2'h1 : 2'h2))
    else $error("failure counter passed its limit");
  a_error_stays_set: assert property (o_spi_error && !i_spi_error_clear
    |=> o_spi_error)
    else $error("spi error flag dropped by itself");
  a_cfg_normal_only: assert property ((o_period_select !=
    $past(o_period_select) || o_window_type_select !=
    $past(o_window_type_select)) |->
    $past(i_device_mode) == watchdog_pkg::MODE_NORMAL)
    else $error("configuration changed outside normal mode");
  a_sleep_wd_off: assert property (
    i_device_mode == watchdog_pkg::MODE_SLEEP [*4] |->
    o_watchdog_state == watchdog_pkg::WD_OFF &&
    o_failure_counter == 2'h0)
    else $error("watchdog active in sleep mode");
  a_readback_zero_bits: assert property (o_control_readback[4:0] ==
    {2'h0, o_period_select} &&
    o_control_readback[5] == o_window_type_select)
    else $error("control readback does not match");

  c_reset_request: cover property (o_reset_output_low);
  c_spi_error: cover property ($rose(o_spi_error));
  c_long_left: cover property (o_watchdog_state == watchdog_pkg::WD_LONG
    ##1 o_watchdog_state != watchdog_pkg::WD_LONG);
endmodule : window_timeout_watchdog_props

bind window_timeout_watchdog window_timeout_watchdog_props #(
  .TICK_CYCLES(TICK_CYCLES)
) props_i (.i_clock, .i_reset, .i_device_mode, .i_development_mode,
  .i_failure_config, .i_fail_safe_on_failure, .i_spi_error_clear,
  .o_reset_output_low, .o_enter_restart, .o_enter_fail_safe, .o_spi_error,
  .o_window_type_select, .o_period_select, .o_failure_counter,
  .o_control_readback, .o_watchdog_state);

// *** verification/spi_master_model.sv ***
module spi_master_model (
  output logic o_spi_clock,
  output logic o_chip_select_low,
  output logic o_spi_data_in
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_spi_clock       = 1'b0;
    o_chip_select_low = 1'b1;
    o_spi_data_in     = 1'b0;
  end
  // lsb first; the link clock only runs inside a frame
  task automatic send(input logic [15:0] frame);
    #17.3;
    o_chip_select_low = 1'b0;
    for (int i = 0; i < 16; i++) begin
      o_spi_data_in = frame[i];
      #62.5 o_spi_clock = 1'b1;
      #62.5 o_spi_clock = 1'b0;
    end
    #62.5 o_chip_select_low = 1'b1;
    // released line has no pull, so show the opposite of the last bit
    o_spi_data_in = ~o_spi_data_in;
    #400;
  endtask : send
endmodule : spi_master_model

// *** verification/tb_window_timeout_watchdog.sv ***
module tb_window_timeout_watchdog;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TICK = 40;
  logic                       i_clock = 1'b0;
  logic                       i_reset = 1'b1;
  logic                       sck, cs_low, mosi;
  watchdog_pkg::device_mode_t i_device_mode = watchdog_pkg::MODE_INIT;
  logic                       i_development_mode = 1'b0;
  logic [1:0]                 i_failure_config = 2'h0;
  logic                       fs = 1'b0;
  logic                       i_reset_released = 1'b0;
  logic                       i_spi_error_clear = 1'b0;
  logic                       o_reset_output_low, o_enter_restart;
  logic                       o_enter_fail_safe, o_enter_normal, o_spi_error;
  logic                       o_window_type_select, o_step_a, o_step_b;
  logic [2:0]                 o_period_select;
  logic [1:0]                 o_failure_counter, lim;
  logic [7:0]                 o_control_readback, d, e;
  watchdog_pkg::wd_state_t    o_watchdog_state;
  int bad_count = 0, cmp_count = 0, fails = 0, n, f0, pc;
  int ms_tab[8] = '{10, 20, 50, 100, 200, 500, 1000, 10000};

  spi_master_model spi_master_model_i (.o_spi_clock(sck),
    .o_chip_select_low(cs_low), .o_spi_data_in(mosi));
  window_timeout_watchdog #(.TICK_CYCLES(TICK)) window_timeout_watchdog_i (
    .i_clock, .i_reset, .i_enable(1'b1), .i_spi_clock(sck),
    .i_chip_select_low(cs_low), .i_spi_data_in(mosi), .i_device_mode,
    .i_development_mode, .i_failure_config, .i_fail_safe_on_failure(fs),
    .i_reset_released, .i_spi_error_clear, .o_reset_output_low,
    .o_enter_restart, .o_enter_fail_safe, .o_enter_normal, .o_spi_error,
    .o_window_type_select, .o_period_select, .o_failure_counter,
    .o_stop_disable_step_a(o_step_a), .o_stop_disable_step_b(o_step_b),
    .o_control_readback, .o_watchdog_state);

  always #12.5 i_clock = ~i_clock;
  always @(posedge i_clock) if (o_reset_output_low === 1'b1) fails++;

  function automatic logic [7:0] ctl(input logic w, input logic [2:0] p,
                                     input logic b3);
    logic [7:0] v;
    v = {2'b00, w, 1'b0, b3, p};
    v[7] = ^v[6:0];
    return v;
  endfunction : ctl

  task automatic stop_test();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic send(input logic [7:0] v);
    f0 = fails;
    spi_master_model_i.send({v, 1'b1, watchdog_pkg::ADDR_WD_CONTROL});
    @(negedge i_clock);
  endtask : send

  task automatic wait_fail(input int bound);
    n = 0;
    while (fails == f0) begin
      @(negedge i_clock);
      n++;
      if (n > bound) begin
        chk("reset_request", 1'b0, 1'b1);
        stop_test();
      end
    end
  endtask : wait_fail

  // the bench plays the mode controller around a watchdog failure
  task automatic recover(input logic [1:0] cnt);
    i_device_mode = fs ? watchdog_pkg::MODE_FAIL_SAFE
                       : watchdog_pkg::MODE_RESTART;
    i_reset_released = 1'b0;
    repeat (4) @(negedge i_clock);
    if (!fs) chk("state_off", o_watchdog_state, watchdog_pkg::WD_OFF);
    i_reset_released = 1'b1;
    for (int k = 0; k < 40 && o_enter_normal !== 1'b1; k++)
      @(negedge i_clock);
    chk("enter_normal", o_enter_normal, 1'b1);
    i_device_mode = watchdog_pkg::MODE_NORMAL;
    repeat (2) @(negedge i_clock);
    chk("state_long", o_watchdog_state, watchdog_pkg::WD_LONG);
    chk("fail_count", o_failure_counter, cnt);
    f0 = fails;
  endtask : recover

  initial begin
    n = $urandom(65989);
    i_failure_config = 2'($urandom_range(3, 0));
    fs = 1'($urandom_range(1, 0));
    lim = (i_failure_config == 2'h1) ? 2'h1 : 2'h2;
    repeat (2) @(negedge i_clock);
    i_reset = 1'b0;
    chk("window_default", o_window_type_select, 1'b0);
    chk("state_reset", o_watchdog_state, watchdog_pkg::WD_OFF);
    i_reset_released = 1'b1;
    repeat (3) @(negedge i_clock);
    chk("init_long", o_watchdog_state, watchdog_pkg::WD_LONG);
    i_device_mode = watchdog_pkg::MODE_NORMAL;
    d = ctl(1'b1, 3'($urandom_range(7, 0)), 1'b1);
    d[7] = ~d[7];
    send(d);
    chk("parity_error", o_spi_error, 1'b1);
    chk("parity_ignored", o_window_type_select, 1'b0);
    i_spi_error_clear = 1'b1;
    @(negedge i_clock);
    i_spi_error_clear = 1'b0;
    @(negedge i_clock);
    chk("error_cleared", o_spi_error, 1'b0);
    send(ctl(1'b1, 3'h0, 1'b1));
    e = ctl(1'b1, 3'h0, 1'b0);
    chk("window_set", o_window_type_select, 1'b1);
    chk("readback", o_control_readback[6:0], e[6:0]);
    chk("closed_first", o_watchdog_state, watchdog_pkg::WD_CLOSED);
    send(ctl(1'b1, 3'h0, 1'b0));
    wait_fail(100);
    recover(2'h1);
    for (int k = 0; k < 2; k++) begin
      wait_fail(8300);
      chk("long_window", n >= 7900 && n <= 8100, 1'b1);
      recover((k + 2 > lim) ? lim : 2'(k + 2));
    end
    d[2:0] = 3'($urandom_range(2, 0));
    pc = ms_tab[d[2:0]] * TICK;
    send(ctl(1'b0, d[2:0], 1'b0));
    chk("count_clear", o_failure_counter, 2'h0);
    chk("period_set", o_period_select, d[2:0]);
    repeat ($urandom_range(pc / 2, pc / 4)) @(negedge i_clock);
    send(ctl(1'b0, d[2:0], 1'b0));
    wait_fail(pc + 100);
    chk("expiry", n >= pc - 50 && n <= pc + 50, 1'b1);
    recover(2'h1);
    spi_master_model_i.send({8'h04, 1'b1, watchdog_pkg::ADDR_WAKE_CONTROL});
    send(ctl(1'b0, d[2:0], 1'b0) ^ 8'hc0);
    chk("steps", {o_step_a, o_step_b}, 2'h3);
    i_device_mode = watchdog_pkg::MODE_STOP;
    send(ctl(1'b0, d[2:0], 1'b0));
    chk("stop_long", o_watchdog_state, watchdog_pkg::WD_LONG);
    chk("steps_clr", {o_step_a, o_step_b}, 2'h0);
    i_device_mode = watchdog_pkg::MODE_NORMAL;
    send(e);
    repeat ($urandom_range(340, 220)) @(negedge i_clock);
    send(e);
    chk("open_trig", o_watchdog_state, watchdog_pkg::WD_CLOSED);
    i_development_mode = 1'b1;
    send(ctl(1'b0, 3'h0, 1'b0));
    f0 = fails;
    repeat (800) @(negedge i_clock);
    chk("dev_no_reset", 16'(fails - f0), 16'h0000);
    i_device_mode = watchdog_pkg::MODE_SLEEP;
    repeat (5) @(negedge i_clock);
    chk("sleep_off", o_watchdog_state, watchdog_pkg::WD_OFF);
    chk("sleep_count", o_failure_counter, 2'h0);
    i_development_mode = 1'b0;
    @(negedge i_clock);
    stop_test();
  end
endmodule : tb_window_timeout_watchdog
